//--- hw/ssb_fifo.sv
// Purpose: Small flip-flop FIFO for queued transmit frames.
// Assumes: DEPTH is a power of two.
// Notes: Ready and valid reflect true full and empty.
`timescale 1ns/1ps
module ssb_fifo #(
    parameter int W = 33,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    ssb_stream_if.snk in_s,
    ssb_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] next_mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_s.ready = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_mem[wr_ptr] = in_s.data;
            next_wr_ptr = wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    mem[gi] <= '0;
                end else begin
                    mem[gi] <= next_mem[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule

//--- hw/ssb_pkg.sv
// Purpose: Shared constants for the buffered synchronous serial unit.
// Assumes: 32-bit Avalon-MM register bus, 250 MHz system clock.
// Notes: Offsets are byte addresses of aligned words.
package ssb_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCK_HALF_NS = 24;
    localparam int SCK_HALF_CYC_I = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [3:0] SCK_HALF_CYC = SCK_HALF_CYC_I[3:0];
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = 33;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_TXDATA = 5'h08;
    localparam logic [4:0] OFS_RXDATA = 5'h0c;

    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_TXEN_BIT = 2;
    localparam int CTRL_RXEN_BIT = 3;
    localparam int ST_TX_BUFFER_EMPTY_FLAG_BIT = 0;
    localparam int ST_RX_BUFFER_FULL_FLAG_BIT = 1;
    localparam int ST_OVERRUN_ERROR_FLAG_BIT = 2;
    localparam int ST_TRANSMIT_END_FLAG_BIT = 3;

    localparam logic [1:0] LEN_16 = 2'h1;
    localparam logic [1:0] LEN_32 = 2'h2;
    localparam logic [1:0] LEN_RESET = 2'h1;
    localparam logic [3:0] MASK_16 = 4'h3;
    localparam logic [3:0] MASK_32 = 4'hf;
    localparam logic [5:0] BITS_16 = 6'h10;
    localparam logic [5:0] BITS_32 = 6'h20;
endpackage

//--- hw/ssb_stream_if.sv
// Purpose: Valid/ready word stream between the unit and its FIFO.
// Assumes: Source holds data stable while valid is high and ready low.
// Notes: One word moves on each edge with valid and ready both high.
`timescale 1ns/1ps
interface ssb_stream_if #(parameter int W = 33);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- hw/ssb_top.sv
// Purpose: Buffered synchronous serial unit with Avalon-MM registers.
// Assumes: Unit is link master; serial clock is divided from i_clk.
// Notes: Full frames queue in a FIFO ahead of the shift register.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ssb_top (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [4:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_sck,
    output logic o_mosi,
    output logic o_cs_n,
    input wire logic i_miso
);
    typedef enum logic [0:0] {
        SSB_IDLE = 1'b0,
        SSB_SHIFT = 1'b1
    } ssb_state_e;

    ssb_stream_if #(.W(ssb_pkg::FIFO_WIDTH)) push_s ();
    ssb_stream_if #(.W(ssb_pkg::FIFO_WIDTH)) pop_s ();

    ssb_fifo #(
        .W(ssb_pkg::FIFO_WIDTH),
        .DEPTH(ssb_pkg::FIFO_DEPTH)
    ) u_ssb_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .in_s(push_s),
        .out_s(pop_s)
    );

    logic [1:0] frame_length_sel, next_frame_length_sel;
    logic transmit_enable_bit, next_transmit_enable_bit;
    logic receive_enable_bit, next_receive_enable_bit;
    logic tx_buffer_empty_flag, next_tx_buffer_empty_flag;
    logic rx_buffer_full_flag, next_rx_buffer_full_flag;
    logic overrun_error_flag, next_overrun_error_flag;
    logic transmit_end_flag, next_transmit_end_flag;
    logic [31:0] tx_buf, next_tx_buf;
    logic [3:0] tx_loaded, next_tx_loaded;
    logic [31:0] rx_buf, next_rx_buf;
    logic waitreq, next_waitreq;
    logic [31:0] rdata, next_rdata;
    ssb_state_e state, next_state;
    logic [31:0] serial_shift_reg, next_serial_shift_reg;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic [3:0] div_cnt, next_div_cnt;
    logic sck, next_sck;
    logic cs_n, next_cs_n;
    logic rx_bit, next_rx_bit;
    logic cur_32, next_cur_32;
    logic miso_s1, miso_s2;

    logic fire, rd_fire, wr_fire;
    logic [3:0] need_mask;
    logic [3:0] lanes_loaded;
    logic [31:0] packed_tx;
    logic [31:0] captured;
    logic tick, frame_done;

    assign o_readdata = rdata;
    assign o_waitrequest = waitreq;
    assign o_sck = sck;
    assign o_mosi = serial_shift_reg[31];
    assign o_cs_n = cs_n;

    // A full tx buffer is offered to the FIFO; it stays put while full.
    assign push_s.valid = !tx_buffer_empty_flag;
    assign push_s.data = {(frame_length_sel == ssb_pkg::LEN_32), packed_tx};
    assign pop_s.ready = (state == SSB_IDLE) && transmit_enable_bit;

    // Waitrequest is low for one cycle; that edge commits the access.
    assign fire = (i_read || i_write) && !waitreq;
    assign rd_fire = fire && i_read;
    assign wr_fire = fire && i_write;
    assign tick = (div_cnt == ssb_pkg::SCK_HALF_CYC - 4'h1);
    assign frame_done = (state == SSB_SHIFT) && tick && sck
        && (bit_cnt == 6'h01);
    assign captured = {serial_shift_reg[30:0], rx_bit};

    always_comb begin
        need_mask = ssb_pkg::MASK_16;
        if (frame_length_sel == ssb_pkg::LEN_32) begin
            need_mask = ssb_pkg::MASK_32;
        end
        // Byte 0 sits at the top so it leaves first, MSB first.
        packed_tx = {tx_buf[7:0], tx_buf[15:8], 16'h0000};
        if (frame_length_sel == ssb_pkg::LEN_32) begin
            packed_tx = {tx_buf[7:0], tx_buf[15:8], tx_buf[23:16],
                tx_buf[31:24]};
        end
    end

    always_comb begin
        next_frame_length_sel = frame_length_sel;
        next_transmit_enable_bit = transmit_enable_bit;
        next_receive_enable_bit = receive_enable_bit;
        next_tx_buffer_empty_flag = tx_buffer_empty_flag;
        next_rx_buffer_full_flag = rx_buffer_full_flag;
        next_overrun_error_flag = overrun_error_flag;
        next_transmit_end_flag = transmit_end_flag;
        next_tx_buf = tx_buf;
        next_tx_loaded = tx_loaded;
        next_rx_buf = rx_buf;
        next_waitreq = 1'b1;
        next_rdata = rdata;
        lanes_loaded = tx_loaded;
        if ((i_read || i_write) && waitreq) begin
            next_waitreq = 1'b0;
            next_rdata = 32'h0000_0000;
            case (i_address)
                ssb_pkg::OFS_CTRL: begin
                    next_rdata[ssb_pkg::CTRL_LEN_LSB +: 2] = frame_length_sel;
                    next_rdata[ssb_pkg::CTRL_TXEN_BIT] = transmit_enable_bit;
                    next_rdata[ssb_pkg::CTRL_RXEN_BIT] = receive_enable_bit;
                end
                ssb_pkg::OFS_STATUS: begin
                    next_rdata[ssb_pkg::ST_TX_BUFFER_EMPTY_FLAG_BIT] = tx_buffer_empty_flag;
                    next_rdata[ssb_pkg::ST_RX_BUFFER_FULL_FLAG_BIT] = rx_buffer_full_flag;
                    next_rdata[ssb_pkg::ST_OVERRUN_ERROR_FLAG_BIT] = overrun_error_flag;
                    next_rdata[ssb_pkg::ST_TRANSMIT_END_FLAG_BIT] = transmit_end_flag;
                end
                ssb_pkg::OFS_TXDATA: begin
                    next_rdata = tx_buf;
                end
                ssb_pkg::OFS_RXDATA: begin
                    next_rdata = rx_buf;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
        if (wr_fire && i_address == ssb_pkg::OFS_CTRL && i_byteenable[0]) begin
            next_frame_length_sel = i_writedata[ssb_pkg::CTRL_LEN_LSB +: 2];
            next_transmit_enable_bit = i_writedata[ssb_pkg::CTRL_TXEN_BIT];
            next_receive_enable_bit = i_writedata[ssb_pkg::CTRL_RXEN_BIT];
        end
        if (wr_fire && i_address == ssb_pkg::OFS_STATUS && i_byteenable[0]) begin
            if (i_writedata[ssb_pkg::ST_OVERRUN_ERROR_FLAG_BIT]) begin
                next_overrun_error_flag = 1'b0;
            end
            if (i_writedata[ssb_pkg::ST_TRANSMIT_END_FLAG_BIT]) begin
                next_transmit_end_flag = 1'b0;
            end
        end
        // Lanes are ignored while a loaded frame waits for FIFO room.
        if (wr_fire && i_address == ssb_pkg::OFS_TXDATA
            && tx_buffer_empty_flag) begin
            for (int i = 0; i < 4; i++) begin
                if (i_byteenable[i]) begin
                    next_tx_buf[8*i +: 8] = i_writedata[8*i +: 8];
                    lanes_loaded[i] = 1'b1;
                end
            end
            next_tx_loaded = lanes_loaded;
            if ((lanes_loaded & need_mask) == need_mask) begin
                next_tx_buffer_empty_flag = 1'b0;
            end
        end
        if (push_s.valid && push_s.ready) begin
            next_tx_loaded = 4'h0;
            next_tx_buffer_empty_flag = 1'b1;
        end
        // The read clears full; a frame landing the same edge wins.
        if (rd_fire && i_address == ssb_pkg::OFS_RXDATA) begin
            next_rx_buffer_full_flag = 1'b0;
        end
        if (frame_done) begin
            if (tx_buffer_empty_flag && !pop_s.valid) begin
                next_transmit_end_flag = 1'b1;
            end
            if (receive_enable_bit) begin
                if (rx_buffer_full_flag && !(rd_fire
                    && i_address == ssb_pkg::OFS_RXDATA)) begin
                    // Unread data is kept; the new frame is lost.
                    next_overrun_error_flag = 1'b1;
                end else begin
                    next_rx_buffer_full_flag = 1'b1;
                    if (cur_32) begin
                        next_rx_buf = {captured[7:0], captured[15:8],
                            captured[23:16], captured[31:24]};
                    end else begin
                        next_rx_buf = {16'h0000, captured[7:0],
                            captured[15:8]};
                    end
                end
            end
        end
    end

    always_comb begin
        next_state = state;
        next_serial_shift_reg = serial_shift_reg;
        next_bit_cnt = bit_cnt;
        next_div_cnt = div_cnt;
        next_sck = sck;
        next_cs_n = cs_n;
        next_rx_bit = rx_bit;
        next_cur_32 = cur_32;
        case (state)
            SSB_IDLE: begin
                next_sck = 1'b0;
                next_cs_n = 1'b1;
                next_div_cnt = 4'h0;
                if (pop_s.valid && pop_s.ready) begin
                    next_serial_shift_reg = pop_s.data[31:0];
                    next_cur_32 = pop_s.data[32];
                    next_bit_cnt = pop_s.data[32] ? ssb_pkg::BITS_32
                        : ssb_pkg::BITS_16;
                    next_cs_n = 1'b0;
                    next_state = SSB_SHIFT;
                end
            end
            SSB_SHIFT: begin
                next_div_cnt = div_cnt + 4'h1;
                if (tick) begin
                    next_div_cnt = 4'h0;
                    if (!sck) begin
                        next_sck = 1'b1;
                        next_rx_bit = miso_s2;
                    end else begin
                        next_sck = 1'b0;
                        next_serial_shift_reg = captured;
                        next_bit_cnt = bit_cnt - 6'h01;
                        if (bit_cnt == 6'h01) begin
                            // Select lifts for a cycle so the far end sees
                            // every frame start on a fresh select edge.
                            next_cs_n = 1'b1;
                            next_state = SSB_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_state = SSB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frame_length_sel <= ssb_pkg::LEN_RESET;
            transmit_enable_bit <= 1'b0;
            receive_enable_bit <= 1'b0;
            tx_buffer_empty_flag <= 1'b1;
            rx_buffer_full_flag <= 1'b0;
            overrun_error_flag <= 1'b0;
            transmit_end_flag <= 1'b0;
            tx_buf <= 32'h0000_0000;
            tx_loaded <= 4'h0;
            rx_buf <= 32'h0000_0000;
            waitreq <= 1'b1;
            rdata <= 32'h0000_0000;
            state <= SSB_IDLE;
            serial_shift_reg <= 32'h0000_0000;
            bit_cnt <= 6'h00;
            div_cnt <= 4'h0;
            sck <= 1'b0;
            cs_n <= 1'b1;
            rx_bit <= 1'b0;
            cur_32 <= 1'b0;
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            frame_length_sel <= next_frame_length_sel;
            transmit_enable_bit <= next_transmit_enable_bit;
            receive_enable_bit <= next_receive_enable_bit;
            tx_buffer_empty_flag <= next_tx_buffer_empty_flag;
            rx_buffer_full_flag <= next_rx_buffer_full_flag;
            overrun_error_flag <= next_overrun_error_flag;
            transmit_end_flag <= next_transmit_end_flag;
            tx_buf <= next_tx_buf;
            tx_loaded <= next_tx_loaded;
            rx_buf <= next_rx_buf;
            waitreq <= next_waitreq;
            rdata <= next_rdata;
            state <= next_state;
            serial_shift_reg <= next_serial_shift_reg;
            bit_cnt <= next_bit_cnt;
            div_cnt <= next_div_cnt;
            sck <= next_sck;
            cs_n <= next_cs_n;
            rx_bit <= next_rx_bit;
            cur_32 <= next_cur_32;
            miso_s1 <= i_miso;
            miso_s2 <= miso_s1;
        end
    end
endmodule

//--- tb/ssb_chk.sv
// Purpose: Port-level assertions for the buffered serial unit.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Frame checks assume the unit drives the serial clock.
`timescale 1ns/1ps
module ssb_chk (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [4:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic o_sck,
    input wire logic o_mosi,
    input wire logic o_cs_n,
    input wire logic i_miso
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    logic sck_q;
    logic [5:0] rise_cnt;
    // Rises are counted per frame so a short or long frame shows at its end.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sck_q <= 1'b0;
            rise_cnt <= 6'h00;
        end else begin
            sck_q <= o_sck;
            rise_cnt <= o_cs_n ? 6'h00 : rise_cnt + {5'h00, o_sck & ~sck_q};
        end
    end
    sequence s_sck_high;
        o_sck [*6] ##1 !o_sck;
    endsequence
    sequence s_sck_low;
        !o_sck [*6] ##1 o_sck;
    endsequence
    a_wait_answer: assert property ((i_read || i_write) && o_waitrequest
        |=> !o_waitrequest ##1 o_waitrequest)
        else $error("waitrequest did not answer in one cycle");
    a_wait_idle: assert property (!i_read && !i_write && o_waitrequest
        |=> o_waitrequest)
        else $error("waitrequest dropped without a request");
    a_unmapped_zero: assert property (i_read && o_waitrequest &&
        (i_address[4] || i_address[1:0] != 2'h0) |=> o_readdata == 32'h0)
        else $error("unmapped read returned nonzero");
    a_frame_len: assert property ($rose(o_cs_n) |->
        rise_cnt == ssb_pkg::BITS_16 || rise_cnt == ssb_pkg::BITS_32)
        else $error("frame bit count wrong");
    a_sck_idle: assert property (o_cs_n |-> !o_sck)
        else $error("serial clock active while deselected");
    a_sck_high: assert property ($rose(o_sck) |-> s_sck_high)
        else $error("serial clock high phase wrong");
    a_sck_lead: assert property ($fell(o_cs_n) |-> s_sck_low)
        else $error("first serial clock rise mistimed");
    a_sck_low: assert property ($fell(o_sck) && !o_cs_n |-> s_sck_low)
        else $error("serial clock low phase wrong");
    a_mosi_fall: assert property ($changed(o_mosi) && !o_cs_n |->
        $fell(o_sck) || $fell(o_cs_n))
        else $error("data out changed away from a falling clock");
endmodule

//--- tb/ssb_eeprom_model.sv
// Purpose: Behavioural serial memory at the far end of the link.
// Assumes: Mode 0, first byte MSB first, unit drives clock and select.
// Notes: Command codes are arbitrary; memory data is a fixed address hash.
`timescale 1ns/1ps
module ssb_eeprom_model #(
    parameter logic [7:0] CMD_STATUS = 8'h05,
    parameter logic [7:0] CMD_READ = 8'h03
) (
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_cs_n,
    output logic o_miso
);
    logic [7:0] rx, cmd, hi;
    logic [7:0] out = 8'ha5;
    logic tog = 1'b0;
    int cnt = 0;
    int busy = 2;
    always @(negedge i_cs_n) begin
        cnt = 0;
        out = 8'ha5;
    end
    always @(posedge i_sck) begin
        rx = {rx[6:0], i_mosi};
        cnt = cnt + 1;
        if (cnt == 8) cmd = rx;
        if (cnt == 16) hi = rx;
        if (cnt == 16 && cmd == CMD_STATUS && busy > 0) busy = busy - 1;
    end
    always @(negedge i_sck) begin
        if (cnt % 8 != 0) out = {out[6:0], 1'b0};
        else if (cnt == 8 && cmd == CMD_STATUS) out = {7'h00, busy != 0};
        else if (cnt == 24 && cmd == CMD_READ) out = hi ^ rx ^ 8'h3c;
        else out = 8'ha5;
    end
    // Deselected output toggles so a stale bit is never mistaken for data.
    always @(posedge i_clk) tog <= ~tog;
    assign o_miso = i_cs_n ? tog : out[7];
endmodule

//--- tb/ssb_tb_top.sv
// Purpose: Self-checking bench for the buffered serial unit.
// Assumes: Avalon master waits for waitrequest low before releasing.
// Notes: Expected receive data follows the memory model's fixed replies.
`timescale 1ns/1ps
module ssb_tb_top;
    localparam logic [7:0] CMD_ST = 8'h05;
    localparam logic [7:0] CMD_RD = 8'h03;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [4:0] i_address = 5'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [3:0] i_byteenable = 4'h0;
    logic [31:0] i_writedata = 32'h0000_0000;
    logic [31:0] o_readdata, rd;
    logic o_waitrequest, o_sck, o_mosi, o_cs_n, i_miso, write_in_progress_bit;
    logic [7:0] hi, lo;
    int failures = 0;
    int samples_checked = 0;
    int n;
    always #2 i_clk = ~i_clk;
    ssb_top u_ssb_top (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_byteenable(i_byteenable), .i_writedata(i_writedata),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .o_sck(o_sck), .o_mosi(o_mosi), .o_cs_n(o_cs_n), .i_miso(i_miso));
    ssb_eeprom_model #(.CMD_STATUS(CMD_ST), .CMD_READ(CMD_RD))
        u_ssb_eeprom_model (.i_clk(i_clk), .i_sck(o_sck), .i_mosi(o_mosi),
        .i_cs_n(o_cs_n), .o_miso(i_miso));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Waitrequest is registered, so its value before the edge is the one
    // the edge samples; inputs still change only after rising edges.
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] be);
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= be;
        i_write <= w;
        i_read <= ~w;
        @(posedge i_clk);
        while (o_waitrequest !== 1'b0) begin
            @(posedge i_clk);
        end
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk);
    endtask
    task rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'h0);
        chk(nm, rd, e);
    endtask
    task poll(input int b);
        rd = 32'h0000_0000;
        while (rd[b] !== 1'b1) begin
            bus(1'b0, ssb_pkg::OFS_STATUS, 32'h0000_0000, 4'h0);
        end
    endtask
    function automatic logic [31:0] exp_rd(input logic [7:0] h, l);
        return {h ^ l ^ 8'h3c, 24'ha5_a5a5};
    endfunction
    initial begin
        void'($urandom(32'hdd69_ee72));
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        rd_chk("ctrl", ssb_pkg::OFS_CTRL, 32'h0000_0001);
        rd_chk("status", ssb_pkg::OFS_STATUS, 32'h0000_0001);
        bus(1'b1, 5'h10, 32'hffff_ffff, 4'hf);
        rd_chk("unmapped", 5'h10, 32'h0000_0000);
        rd_chk("ctrl_kept", ssb_pkg::OFS_CTRL, 32'h0000_0001);
        // Five frames with transmit off: four fill the queue, one waits.
        bus(1'b1, ssb_pkg::OFS_CTRL, 32'h0000_0009, 4'h1);
        for (n = 0; n < 5; n++) begin
            bus(1'b1, ssb_pkg::OFS_TXDATA, $urandom | 32'h1010_1010, 4'h1);
            rd_chk("tx_buffer_empty_flag_half", ssb_pkg::OFS_STATUS, 32'h0000_0001);
            bus(1'b1, ssb_pkg::OFS_TXDATA, $urandom | 32'h1010_1010, 4'h2);
        end
        rd_chk("tx_buffer_empty_flag_full", ssb_pkg::OFS_STATUS, 32'h0000_0000);
        bus(1'b1, ssb_pkg::OFS_CTRL, 32'h0000_000d, 4'h1);
        poll(3);
        chk("overrun", rd, 32'h0000_000f);
        bus(1'b1, ssb_pkg::OFS_STATUS, 32'h0000_000c, 4'h1);
        rd_chk("rx16", ssb_pkg::OFS_RXDATA, 32'h0000_a5a5);
        rd_chk("rx_buffer_full_flag_clr", ssb_pkg::OFS_STATUS, 32'h0000_0001);
        // Status polling until the busy bit comes back clear.
        n = 0;
        do begin
            bus(1'b1, ssb_pkg::OFS_TXDATA, {16'h0, 8'($urandom), CMD_ST}, 4'h3);
            poll(1);
            chk("poll_st", rd, 32'h0000_000b);
            bus(1'b1, ssb_pkg::OFS_STATUS, 32'h0000_0008, 4'h1);
            rd_chk("rx_st", ssb_pkg::OFS_RXDATA,
                {16'h0, 7'h0, n < 2, 8'ha5});
            write_in_progress_bit = rd[8];
            rd_chk("st_clr", ssb_pkg::OFS_STATUS, 32'h0000_0001);
            n++;
        end while (write_in_progress_bit && n < 5);
        chk("polls", n, 32'h0000_0003);
        bus(1'b1, ssb_pkg::OFS_CTRL, 32'h0000_000e, 4'h1);
        rd_chk("ctrl32", ssb_pkg::OFS_CTRL, 32'h0000_000e);
        for (n = 0; n < 3; n++) begin
            hi = 8'($urandom);
            lo = 8'($urandom);
            bus(1'b1, ssb_pkg::OFS_TXDATA, {8'($urandom), lo, hi, CMD_RD}, 4'hf);
            poll(1);
            chk("rd_st", rd, 32'h0000_000b);
            bus(1'b1, ssb_pkg::OFS_STATUS, 32'h0000_0008, 4'h1);
            rd_chk("rx32", ssb_pkg::OFS_RXDATA, exp_rd(hi, lo));
            rd_chk("rd_clr", ssb_pkg::OFS_STATUS,
                32'h0000_0001);
        end
        // One serial bit period before the enables go off.
        repeat (12) @(posedge i_clk);
        bus(1'b1, ssb_pkg::OFS_CTRL, 32'h0000_0002, 4'h1);
        rd_chk("ctrl_off", ssb_pkg::OFS_CTRL, 32'h0000_0002);
        wrap_up;
    end
    initial begin
        repeat (40000) @(posedge i_clk);
        failures++;
        wrap_up;
    end
endmodule
bind ssb_top ssb_chk u_ssb_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_byteenable(i_byteenable), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_sck(o_sck), .o_mosi(o_mosi), .o_cs_n(o_cs_n), .i_miso(i_miso));
